// ===== rtl/ccs_pkg.sv
package ccs_pkg;

    // =========================================================
    // clock and timing
    // =========================================================
    localparam longint unsigned CLK_PERIOD_NS = 64'd10;
    localparam longint unsigned T_IMMUNITY_NS = 64'd200000;    // 200 us
    localparam longint unsigned T_TERM_NS = 64'd2500000;       // 2.5 ms
    localparam longint unsigned T_PRE_S = 64'd3600;            // 1 hr
    localparam longint unsigned NS_PER_S = 64'd1000000000;
    // every wait rounds down to whole cycles; nothing keeps it at one cycle or more
    localparam longint unsigned CYC_IMMUNITY = T_IMMUNITY_NS / CLK_PERIOD_NS;
    localparam longint unsigned CYC_TERM = T_TERM_NS / CLK_PERIOD_NS;
    localparam longint unsigned CYC_PRE = T_PRE_S * NS_PER_S / CLK_PERIOD_NS;

    // =========================================================
    // widths
    // =========================================================
    localparam int TMR_W = 40;
    localparam int PRE_SEL_W = 2;
    localparam int CC_SEL_W = 5;
    localparam int VREG_W = 6;
    localparam int NFLAG = 9;

    // =========================================================
    // comparator flag positions in the synchronised vector
    // =========================================================
    localparam int F_IN_GOOD = 0;
    localparam int F_IN_OVER = 1;
    localparam int F_PRE_OK = 2;
    localparam int F_AT_TARGET = 3;
    localparam int F_BELOW_RECH = 4;
    localparam int F_BATT_OVP = 5;
    localparam int F_AT_TERM = 6;
    localparam int F_BELOW_HYS = 7;
    localparam int F_NTC_FAULT = 8;

    // =========================================================
    // charge phases
    // =========================================================
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_PRE = 3'h1,
        ST_CC = 3'h2,
        ST_CV = 3'h3,
        ST_TAPER = 3'h4,
        ST_DONE = 3'h5,
        ST_FAULT = 3'h6
    } ccs_state_t;

endpackage : ccs_pkg

// ===== rtl/ccs_sync.sv
module ccs_sync
    import ccs_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } ccs_sync_t;

    ccs_sync_t q;
    ccs_sync_t d;

    // =========================================================
    // two-stage synchroniser; first stage feeds only the second
    // =========================================================
    always_comb
    begin
        d.meta = async_i;
        d.sync = q.meta;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
            q <= '0;
        else
            q <= d;
    end

    assign sync_o = q.sync;

endmodule : ccs_sync

// ===== rtl/ccs_timer.sv
module ccs_timer
    import ccs_pkg::*;
#(
    parameter int W = TMR_W
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic [W-1:0] limit_i,
    output logic expired_o
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic exp;
    } ccs_tmr_t;

    ccs_tmr_t q;
    ccs_tmr_t d;

    // =========================================================
    // counts while run is high, restarts from zero when it drops
    // =========================================================
    always_comb
    begin
        d = q;
        if (!run_i)
        begin
            d.cnt = '0;
            d.exp = 1'b0;
        end
        else if (q.cnt >= limit_i - W'(1))
            d.exp = 1'b1; // holds until run drops
        else
            d.cnt = q.cnt + W'(1);
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
            q <= '0;
        else
            q <= d;
    end

    assign expired_o = q.exp;

endmodule : ccs_timer

// ===== rtl/ccs_sequencer.sv
// Function
// - input leaving its normal range turns the pass switch off at once
// - good input must hold through the immunity time before the path starts
// - after supply rise all settings load defaults and host access is ready
// - path-off forces pass switch off; charge-disable forces charge switch off
// - below pre-charge exit level stay in pre-charge, current from 2-bit field
// - pre-charge timer expiry before exit level ends cycle with timeout fault
// - above exit level enter constant current, current from 5-bit field
// - reaching the 6-bit target voltage moves from constant current to voltage
// - termination is evaluated only while termination enable is one
// - low current starts a delay; current must stay under margin throughout
// - delay expiry with the condition held marks charge complete
// - option zero cuts current at completion, otherwise current keeps tapering
// - termination disabled never starts delay, completes or stops on current
// - new cycle on recycle, host enable or recharge, only with no faults
// - after termination, low battery with good input restarts charging
// - auto recharge only with termination enabled and option zero
// - battery over target by the margin suspends charge and raises a fault
module ccs_sequencer
    import ccs_pkg::*;
#(
    parameter longint unsigned IMM_CYCLES = CYC_IMMUNITY,
    parameter longint unsigned TERM_CYCLES = CYC_TERM,
    parameter longint unsigned PRE_CYCLES = CYC_PRE
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic in_good_i,
    input wire logic in_over_i,
    input wire logic precharge_exit_level_i,
    input wire logic cell_target_voltage_reached_i,
    input wire logic below_recharge_i,
    input wire logic batt_over_voltage_i,
    input wire logic end_of_charge_current_i,
    input wire logic end_current_margin_i,
    input wire logic ntc_fault_i,
    input wire logic input_path_off_i,
    input wire logic charge_disable_i,
    input wire logic charge_enable_i,
    input wire logic term_enable_i,
    input wire logic finish_timer_option_i,
    input wire logic [PRE_SEL_W-1:0] precharge_current_i,
    input wire logic [CC_SEL_W-1:0] fast_current_i,
    input wire logic [VREG_W-1:0] cell_target_voltage_i,
    output logic input_pass_switch_o,
    output logic batt_chg_switch_o,
    output logic charge_current_on_o,
    output logic [2:0] charge_phase_o,
    output logic charge_complete_o,
    output logic timeout_fault_o,
    output logic batt_ovp_fault_o,
    output logic [PRE_SEL_W-1:0] precharge_current_o,
    output logic [CC_SEL_W-1:0] fast_current_o,
    output logic [VREG_W-1:0] cell_target_voltage_o,
    output logic host_if_ready_o,
    output logic defaults_load_o
);

    typedef struct packed {
        ccs_state_t st;
        logic ok_in;
        logic ok_prev;
        logic en_prev;
        logic pass;
        logic bsw;
        logic cur_on;
        logic tmo;
        logic bovp;
        logic armed;
        logic done;
        logic rdy;
        logic ld;
        logic [PRE_SEL_W-1:0] pre_sel;
        logic [CC_SEL_W-1:0] cc_sel;
        logic [VREG_W-1:0] vreg;
    } ccs_core_t;

    ccs_core_t q;
    ccs_core_t d;

    // phases in which the charger sources current
    function automatic logic is_charging(input ccs_state_t s);
        is_charging = (s == ST_PRE) || (s == ST_CC) || (s == ST_CV) || (s == ST_TAPER);
    endfunction : is_charging

    // =========================================================
    // comparator flags
    // =========================================================
    logic [NFLAG-1:0] flag_raw;
    logic [NFLAG-1:0] f;

    assign flag_raw = {ntc_fault_i, end_current_margin_i, end_of_charge_current_i,
                       batt_over_voltage_i, below_recharge_i,
                       cell_target_voltage_reached_i, precharge_exit_level_i,
                       in_over_i, in_good_i};

    ccs_sync #(.W(NFLAG)) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(flag_raw),
        .sync_o(f)
    );

    // =========================================================
    // timers
    // =========================================================
    logic in_ok;
    logic imm_exp;
    logic term_exp;
    logic pre_exp;

    assign in_ok = f[F_IN_GOOD] && !f[F_IN_OVER];

    ccs_timer #(.W(TMR_W)) u_imm (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .run_i(in_ok && !q.ok_in),
        .limit_i(TMR_W'(IMM_CYCLES)),
        .expired_o(imm_exp)
    );

    ccs_timer #(.W(TMR_W)) u_term (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .run_i(q.armed),
        .limit_i(TMR_W'(TERM_CYCLES)),
        .expired_o(term_exp)
    );

    ccs_timer #(.W(TMR_W)) u_pre (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .run_i(q.st == ST_PRE),
        .limit_i(TMR_W'(PRE_CYCLES)),
        .expired_o(pre_exp)
    );

    // =========================================================
    // next state
    // =========================================================
    logic stay;
    logic block;
    logic recycle;
    logic en_edge;
    logic auto_rech;
    logic start;

    always_comb
    begin
        d = q;
        // defaults loaded once, host side ready from then on
        d.rdy = 1'b1;
        d.ld = !q.rdy;
        d.pre_sel = precharge_current_i;
        d.cc_sel = fast_current_i;
        d.vreg = cell_target_voltage_i;
        // qualified input drops one cycle after the flag does
        // and only rises once the immunity timer has run out
        d.ok_in = in_ok && (q.ok_in || imm_exp);
        d.ok_prev = q.ok_in;
        d.en_prev = charge_enable_i;
        d.bovp = f[F_BATT_OVP];
        // fault is cleared by the host dropping charge enable
        if (!charge_enable_i)
            d.tmo = 1'b0;

        stay = q.ok_in && charge_enable_i && !charge_disable_i;
        recycle = q.ok_in && !q.ok_prev;
        en_edge = charge_enable_i && !q.en_prev;
        // recharge after termination with input in range
        // only with termination on and option zero
        auto_rech = (q.st == ST_DONE) && f[F_BELOW_RECH] && q.ok_in
                    && term_enable_i && !finish_timer_option_i;
        block = f[F_NTC_FAULT] || q.tmo || f[F_BATT_OVP] || charge_disable_i;
        start = (recycle || en_edge || auto_rech) && !block && stay;

        // armed on end current, dropped if margin is exceeded
        d.armed = (q.st == ST_CV) && term_enable_i && stay
                  && (q.armed ? f[F_BELOW_HYS] : f[F_AT_TERM]);

        case (q.st)
            ST_IDLE, ST_DONE:
            begin
                if (start)
                begin
                    d.done = 1'b0;
                    d.st = f[F_PRE_OK] ? ST_CC : ST_PRE;
                end
            end
            ST_PRE:
            begin
                if (f[F_PRE_OK])
                    d.st = ST_CC;
                else if (pre_exp)
                begin
                    d.st = ST_FAULT;
                    d.tmo = 1'b1;
                end
            end
            ST_CC:
            begin
                if (f[F_AT_TARGET])
                    d.st = ST_CV;
            end
            ST_CV:
            begin
                // option picks cut-off or continued taper
                if (q.armed && term_exp && f[F_BELOW_HYS] && term_enable_i)
                begin
                    d.done = 1'b1;
                    d.st = finish_timer_option_i ? ST_TAPER : ST_DONE;
                end
            end
            ST_TAPER:
                d.st = ST_TAPER; // taper until the host ends the cycle
            ST_FAULT:
            begin
                if (!q.tmo)
                    d.st = ST_IDLE;
            end
            default:
                d.st = ST_IDLE;
        endcase

        // losing input or permission abandons the cycle
        if (!stay && (q.st != ST_FAULT))
        begin
            d.st = ST_IDLE;
            d.armed = 1'b0;
        end

        // current suspended at once on over-voltage
        // charge-disable forces the charge switch off
        d.cur_on = is_charging(d.st) && !f[F_BATT_OVP] && !f[F_NTC_FAULT]
                   && !charge_disable_i;
        d.bsw = d.cur_on;
        // pass switch follows the qualified input
        d.pass = d.ok_in && !input_path_off_i;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
            q <= '0;
        else
            q <= d;
    end

    // =========================================================
    // outputs, all straight from the state register
    // =========================================================
    assign input_pass_switch_o = q.pass;
    assign batt_chg_switch_o = q.bsw;
    assign charge_current_on_o = q.cur_on;
    assign charge_phase_o = q.st;
    assign charge_complete_o = q.done;
    assign timeout_fault_o = q.tmo;
    assign batt_ovp_fault_o = q.bovp;
    assign precharge_current_o = q.pre_sel;
    assign fast_current_o = q.cc_sel;
    assign cell_target_voltage_o = q.vreg;
    assign host_if_ready_o = q.rdy;
    assign defaults_load_o = q.ld;

    // =========================================================
    // assertions
    // =========================================================
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_pass_in_bad: assert property (!in_ok |=> !input_pass_switch_o)
        else $error("pass switch on with input out of range");
    a_immunity_wait: assert property (in_ok && !q.ok_in && !imm_exp |=> !q.ok_in)
        else $error("input qualified before immunity expiry");
    a_defaults_once: assert property (defaults_load_o |=> !defaults_load_o && host_if_ready_o)
        else $error("defaults load not a single pulse");
    a_path_off: assert property (input_path_off_i |=> !input_pass_switch_o)
        else $error("pass switch on while path off");
    a_chg_disable: assert property (charge_disable_i |=> !batt_chg_switch_o)
        else $error("charge switch on while disabled");
    a_pre_hold: assert property (q.st == ST_PRE && !f[F_PRE_OK] && !pre_exp |=> q.st inside {ST_PRE, ST_IDLE})
        else $error("left pre-charge below exit level");
    a_pre_timeout: assert property (q.st == ST_PRE && !f[F_PRE_OK] && pre_exp && stay |=> timeout_fault_o ##0 charge_phase_o == ST_FAULT)
        else $error("pre-charge timeout not flagged");
    a_cc_entry: assert property (q.st == ST_PRE && f[F_PRE_OK] && stay |=> q.st == ST_CC)
        else $error("no constant current after exit level");
    a_cv_entry: assert property (q.st == ST_CC && f[F_AT_TARGET] && stay |=> q.st == ST_CV)
        else $error("no constant voltage at target");
    a_term_gated: assert property (!term_enable_i |=> !q.armed ##0 !$rose(charge_complete_o))
        else $error("termination active while disabled");
    a_done_cut: assert property (q.st == ST_CV && q.armed && term_exp && f[F_BELOW_HYS] && term_enable_i && stay && !finish_timer_option_i |=> charge_complete_o && !charge_current_on_o)
        else $error("current not cut at completion");
    a_ovp_cut: assert property (f[F_BATT_OVP] |=> !charge_current_on_o && batt_ovp_fault_o)
        else $error("charging not suspended on over-voltage");
    a_no_auto_opt: assert property (q.st == ST_DONE && finish_timer_option_i && !recycle && !en_edge |=> q.st inside {ST_DONE, ST_IDLE})
        else $error("auto recharge with option set");

    c_complete: cover property (q.st == ST_CV ##1 q.st == ST_DONE);
    c_taper: cover property (q.st == ST_CV ##1 q.st == ST_TAPER);
    c_timeout: cover property ($rose(timeout_fault_o));
    c_recharge: cover property (q.st == ST_DONE ##1 q.st inside {ST_PRE, ST_CC});

endmodule : ccs_sequencer

// ===== dv/ccs_env_model.sv
// =========================================================
// comparator bank model
// =========================================================
// battery level: 0 deep, 1 above exit, 2 above recharge, 3 at target,
// 4 over target plus margin; current level: 0 high, 1 at end point,
// 2 inside margin, 3 above margin; input level: 0 low, 1 good, 2 over
module ccs_env_model (
    input wire logic [2:0] batt_lvl_i,
    input wire logic [1:0] cur_lvl_i,
    input wire logic [1:0] vin_lvl_i,
    output logic in_good_o,
    output logic in_over_o,
    output logic pre_ok_o,
    output logic at_target_o,
    output logic below_rech_o,
    output logic batt_ovp_o,
    output logic at_end_o,
    output logic in_margin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // levels are ordered, so one compare decodes each flag except the margin, which takes two
    assign in_good_o = (vin_lvl_i != 2'h0);
    assign in_over_o = (vin_lvl_i == 2'h2);
    assign pre_ok_o = (batt_lvl_i >= 3'h1);
    assign at_target_o = (batt_lvl_i >= 3'h3);
    assign below_rech_o = (batt_lvl_i < 3'h2);
    assign batt_ovp_o = (batt_lvl_i == 3'h4);
    assign at_end_o = (cur_lvl_i == 2'h1);
    // margin holds while current stays under end point plus hysteresis
    assign in_margin_o = (cur_lvl_i == 2'h1) || (cur_lvl_i == 2'h2);
endmodule : ccs_env_model

// ===== dv/tb_charge_cycle_sequencer.sv
module tb_charge_cycle_sequencer
    import ccs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // =========================================================
    // stimulus and observation
    // =========================================================
    // short counts keep the run small; expectations derive from them
    localparam int IMM = 8;
    localparam int TERM = 16;
    localparam int PRE = 32;
    localparam int PH = 0;
    localparam int PS = 1;
    localparam int CUR = 2;
    localparam int CMP = 3;
    localparam int TMO = 4;
    localparam int OVP = 5;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [2:0] batt = 3'h0;
    logic [1:0] cur = 2'h0;
    logic [1:0] vin = 2'h0;
    logic ntc = 1'b0;
    logic path_off = 1'b0;
    logic chg_dis = 1'b0;
    logic chg_en = 1'b0;
    logic term_en = 1'b0;
    logic opt = 1'b0;
    logic [1:0] pre_sel = 2'h0;
    logic [4:0] cc_sel = 5'h00;
    logic [5:0] vreg = 6'h00;
    logic in_good, in_over, pre_ok, at_tgt, below_rech, b_ovp, at_end, in_margin;
    logic pass_o, sw_o, cur_o, cmp_o, tmo_o, ovp_o, rdy_o, load_o;
    logic [2:0] ph_o;
    logic [1:0] pre_o;
    logic [4:0] cc_o;
    logic [5:0] vreg_o;
    int miscompares = 0;
    int num_checks = 0;

    // free-running system clock
    always #5ns sys_clk_i = ~sys_clk_i;

    ccs_env_model env (
        .batt_lvl_i(batt), .cur_lvl_i(cur), .vin_lvl_i(vin),
        .in_good_o(in_good), .in_over_o(in_over), .pre_ok_o(pre_ok),
        .at_target_o(at_tgt), .below_rech_o(below_rech), .batt_ovp_o(b_ovp),
        .at_end_o(at_end), .in_margin_o(in_margin)
    );

    ccs_sequencer #(.IMM_CYCLES(IMM), .TERM_CYCLES(TERM), .PRE_CYCLES(PRE)) dut (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .in_good_i(in_good), .in_over_i(in_over),
        .precharge_exit_level_i(pre_ok), .cell_target_voltage_reached_i(at_tgt),
        .below_recharge_i(below_rech), .batt_over_voltage_i(b_ovp),
        .end_of_charge_current_i(at_end), .end_current_margin_i(in_margin),
        .ntc_fault_i(ntc), .input_path_off_i(path_off), .charge_disable_i(chg_dis),
        .charge_enable_i(chg_en), .term_enable_i(term_en),
        .finish_timer_option_i(opt), .precharge_current_i(pre_sel),
        .fast_current_i(cc_sel), .cell_target_voltage_i(vreg),
        .input_pass_switch_o(pass_o), .batt_chg_switch_o(sw_o),
        .charge_current_on_o(cur_o), .charge_phase_o(ph_o),
        .charge_complete_o(cmp_o), .timeout_fault_o(tmo_o),
        .batt_ovp_fault_o(ovp_o), .precharge_current_o(pre_o),
        .fast_current_o(cc_o), .cell_target_voltage_o(vreg_o),
        .host_if_ready_o(rdy_o), .defaults_load_o(load_o)
    );

    // =========================================================
    // shared helpers
    // =========================================================
    task automatic ck(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask : ck

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [7:0] pick(input int s);
        case (s)
            PH: return 8'(ph_o);
            PS: return 8'(pass_o);
            CUR: return 8'(cur_o);
            CMP: return 8'(cmp_o);
            TMO: return 8'(tmo_o);
            default: return 8'(ovp_o);
        endcase
    endfunction : pick

    // bounded wait; a design that never gets there shows as a mismatch
    task automatic wait_for(input int s, input logic [7:0] e, input int n);
        int i;
        i = 0;
        while (pick(s) !== e && i < n)
        begin
            ck(1);
            i++;
        end
        chk(pick(s), e);
    endtask : wait_for

    task automatic hold(input int s, input logic [7:0] e, input int n);
        repeat (n)
        begin
            ck(1);
            chk(pick(s), e);
        end
    endtask : hold

    // =========================================================
    // scenarios
    // =========================================================
    task automatic t_reset();
        ck(2);
        chk(pick(PS), 8'h00);
        chk(8'(rdy_o), 8'h00);
        rst_n_i = 1'b1;
        ck(1);
        chk(8'(load_o), 8'h01);
        chk(8'(rdy_o), 8'h01);
        ck(1);
        chk(8'(load_o), 8'h00);
    endtask : t_reset

    task automatic t_input();
        // a good level shorter than the immunity time must not start the path
        vin = 2'h1;
        ck(4);
        vin = 2'h0;
        hold(PS, 8'h00, 20);
        vin = 2'h1;
        hold(PS, 8'h00, IMM);
        wait_for(PS, 8'h01, 16);
        path_off = 1'b1;
        ck(2);
        chk(pick(PS), 8'h00);
        path_off = 1'b0;
        wait_for(PS, 8'h01, 4);
        vin = 2'h2;
        wait_for(PS, 8'h00, 4);
        vin = 2'h1;
        hold(PS, 8'h00, IMM);
        wait_for(PS, 8'h01, 16);
        vin = 2'h0;
        wait_for(PS, 8'h00, 4);
        vin = 2'h1;
        wait_for(PS, 8'h01, 20);
    endtask : t_input

    task automatic t_cycle();
        term_en = 1'b1;
        pre_sel = 2'h2;
        cc_sel = 5'h15;
        vreg = 6'h21;
        chg_en = 1'b1;
        wait_for(PH, ST_PRE, 4);
        chk(8'(pre_o), 8'h02);
        chk(8'(cc_o), 8'h15);
        chk(8'(vreg_o), 8'h21);
        batt = 3'h1;
        wait_for(PH, ST_CC, 5);
        batt = 3'h3;
        wait_for(PH, ST_CV, 5);
        cur = 2'h1;
        hold(PH, ST_CV, TERM);
        wait_for(PH, ST_DONE, 10);
        chk(pick(CMP), 8'h01);
        chk(pick(CUR), 8'h00);
        cur = 2'h0;
        batt = 3'h1;
        wait_for(PH, ST_CC, 6);
        chk(pick(CMP), 8'h00);
    endtask : t_cycle

    task automatic t_margin();
        // current leaving the margin mid-delay must void that delay
        batt = 3'h3;
        wait_for(PH, ST_CV, 5);
        cur = 2'h1;
        ck(6);
        cur = 2'h3;
        ck(4);
        cur = 2'h1;
        hold(PH, ST_CV, TERM);
        wait_for(PH, ST_DONE, 12);
    endtask : t_margin

    task automatic t_options();
        // option set: a low battery after completion must not restart charging
        opt = 1'b1;
        batt = 3'h1;
        hold(PH, ST_DONE, 6);
        batt = 3'h3;
        chg_en = 1'b0;
        cur = 2'h0;
        term_en = 1'b0;
        wait_for(PH, ST_IDLE, 4);
        chg_en = 1'b1;
        wait_for(PH, ST_CV, 8);
        cur = 2'h1;
        hold(PH, ST_CV, 40);
        chk(pick(CMP), 8'h00);
        chk(pick(CUR), 8'h01);
        term_en = 1'b1;
        opt = 1'b1;
        cur = 2'h0;
        ck(4);
        cur = 2'h1;
        wait_for(PH, ST_TAPER, 30);
        chk(pick(CUR), 8'h01);
        chk(pick(CMP), 8'h01);
        batt = 3'h1;
        cur = 2'h0;
        hold(PH, ST_TAPER, 10);
    endtask : t_options

    task automatic t_faults();
        chg_en = 1'b0;
        opt = 1'b0;
        wait_for(PH, ST_IDLE, 4);
        chg_en = 1'b1;
        wait_for(PH, ST_CC, 4);
        chk(8'(sw_o), 8'h01);
        chg_dis = 1'b1;
        ck(2);
        chk(8'(sw_o), 8'h00);
        chk(pick(PS), 8'h01);
        chg_en = 1'b0;
        ck(1);
        chg_en = 1'b1;
        hold(PH, ST_IDLE, 6);
        chg_dis = 1'b0;
        chg_en = 1'b0;
        ntc = 1'b1;
        ck(4);
        chg_en = 1'b1;
        hold(PH, ST_IDLE, 6);
        ntc = 1'b0;
        chg_en = 1'b0;
        ck(4);
        chg_en = 1'b1;
        wait_for(PH, ST_CC, 4);
        batt = 3'h4;
        wait_for(OVP, 8'h01, 4);
        chk(pick(CUR), 8'h00);
        chg_en = 1'b0;
        ck(2);
        chg_en = 1'b1;
        hold(PH, ST_IDLE, 6);
        batt = 3'h1;
        wait_for(OVP, 8'h00, 4);
        // input recycle with host enable held starts a fresh cycle
        vin = 2'h0;
        ck(6);
        vin = 2'h1;
        wait_for(PH, ST_CC, IMM + 12);
    endtask : t_faults

    task automatic t_timeout();
        chg_en = 1'b0;
        batt = 3'h0;
        wait_for(PH, ST_IDLE, 4);
        // the exit-level flag lags two edges; enabling earlier would skip pre-charge
        ck(3);
        chg_en = 1'b1;
        wait_for(PH, ST_PRE, 4);
        hold(PH, ST_PRE, PRE - 8);
        wait_for(PH, ST_FAULT, 20);
        chk(pick(TMO), 8'h01);
        chk(pick(CUR), 8'h00);
        chg_en = 1'b0;
        wait_for(PH, ST_IDLE, 4);
        chk(pick(TMO), 8'h00);
    endtask : t_timeout

    // =========================================================
    // run control
    // =========================================================
    task automatic final_report();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
        begin
            $display("RESULT: PASS");
        end
        else
        begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    // main sequence
    initial
    begin
        t_reset();
        t_input();
        t_cycle();
        t_margin();
        t_options();
        t_faults();
        t_timeout();
        final_report();
    end

    // the tests need under ten microseconds, so this margin is generous
    initial
    begin
        #100us;
        miscompares++;
        final_report();
    end
endmodule : tb_charge_cycle_sequencer
